// ===== design/lin_mode_map.svh
// Purpose: Constants of the LIN mode controller
// Assumes: 20 MHz clock, one cycle is 50 ns
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef LIN_MODE_MAP_SVH
`define LIN_MODE_MAP_SVH

`define CLK_PERIOD_NS 50
`define RESET_TIME_US 4000
`define RESET_CYCLES ((`RESET_TIME_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_TIME_US 100
`define WAKE_CYCLES (((`WAKE_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DOM_TIME_US 1000
`define DOM_CYCLES (((`DOM_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELECT_WIN_NS 3200
`define SELECT_CYCLES (((`SELECT_WIN_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMR_W 17

`endif

// ===== design/lin_mode_pkg.sv
// Purpose: Types of the LIN mode controller
// Assumes: Nothing
// Notes: Gray codes along fail-safe, normal, silent, sleep
package lin_mode_pkg;
	typedef enum logic [1:0] {
		M_FAILSAFE = 2'b00,
		M_NORMAL = 2'b01,
		M_SILENT = 2'b11,
		M_SLEEP = 2'b10
	} mode_t;
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_LOW = 2'b01,
		W_HELD = 2'b11
	} wake_t;
endpackage

// ===== design/pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input asynchronous to clk
// Notes: Output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and result
	input wire logic pin,
	input wire logic reset_level,
	output logic level
);
	logic s1, s2, s3, next_level;

	// Shift chain; reset level is a constant per instance
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= reset_level;
			s2 <= reset_level;
			s3 <= reset_level;
			level <= reset_level;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end

	// Accept a change once two stages agree
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ===== design/lin_sbc_mode_control.sv
// Purpose: Operating-mode controller of a LIN system basis chip
// Assumes: Supply and bus comparators arrive as asynchronous pins
// Notes: Reset pin is open drain; transmit data pin is two-way in fail-safe
`timescale 1ns/1ps
`default_nettype none
`include "lin_mode_map.svh"
module lin_sbc_mode_control
	import lin_mode_pkg::*;
#(
	parameter int RESET_CYC = `RESET_CYCLES,
	parameter int WAKE_CYC = `WAKE_CYCLES,
	parameter int DOM_CYC = `DOM_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host pins
	input wire logic enable_pin,
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe,
	output logic rxd,
	output logic reset_output_low,
	// Analogue status
	input wire logic battery_uv,
	input wire logic vcc_uv,
	input wire logic bus_dominant,
	input wire logic bus_prewake,
	// Analogue controls
	output logic regulator_on,
	output logic bus_drive_dominant,
	output logic termination_on,
	output logic bus_receiver_on,
	output logic [1:0] mode
);
	//////////////////////////////////////////////////////////////////////////
	logic en_s, txd_s, buv_s, vuv_s, dom_s, pre_s, en_d, dom_d;
	logic [`TMR_W-1:0] rst_cnt, next_rst_cnt;
	logic [`TMR_W-1:0] wake_cnt, next_wake_cnt;
	logic [`TMR_W-1:0] dom_cnt, next_dom_cnt;
	logic [7:0] win_cnt, next_win_cnt;
	logic win_txd, next_win_txd;
	logic rst_low, next_rst_low;
	mode_t st, next_st;
	wake_t wk, next_wk;
	logic src_wake, next_src_wake, src_buv, next_src_buv, buv_entry, next_buv_entry;
	logic next_txd_out, next_txd_oe, next_rxd, next_reg_on, next_drive, next_term, next_rcv;
	logic wake_evt, en_fall, allow_req;

	// Three-flop pin synchronisers
	pin_sync u_en (.clk(clk), .rst_n(rst_n), .pin(enable_pin), .reset_level(1'b0), .level(en_s));
	pin_sync u_txd (.clk(clk), .rst_n(rst_n), .pin(txd_in), .reset_level(1'b1), .level(txd_s));
	pin_sync u_buv (.clk(clk), .rst_n(rst_n), .pin(battery_uv), .reset_level(1'b0), .level(buv_s));
	pin_sync u_vuv (.clk(clk), .rst_n(rst_n), .pin(vcc_uv), .reset_level(1'b0), .level(vuv_s));
	pin_sync u_dom (.clk(clk), .rst_n(rst_n), .pin(bus_dominant), .reset_level(1'b0), .level(dom_s));
	pin_sync u_pre (.clk(clk), .rst_n(rst_n), .pin(bus_prewake), .reset_level(1'b0), .level(pre_s));

	//////////////////////////////////////////////////////////////////////////
	// Edge detect and request gating
	assign en_fall = en_d && !en_s;
	assign allow_req = !rst_low;
	assign wake_evt = (wk == W_HELD) && !dom_s;

	// Reset hold timer: power-up, Vcc undervoltage and battery undervoltage in normal or silent restart it
	always_comb begin
		next_rst_cnt = rst_cnt;
		next_rst_low = rst_low;
		if (vuv_s || ((st == M_NORMAL || st == M_SILENT) && buv_s)) begin
			next_rst_cnt = '0;
			next_rst_low = 1'b1;
		end else if (next_st == M_SLEEP) begin
			next_rst_cnt = '0;
			next_rst_low = 1'b1;
		end else if (rst_low) begin
			if (rst_cnt == `TMR_W'(RESET_CYC - 1)) begin
				next_rst_low = 1'b0;
			end else begin
				next_rst_cnt = rst_cnt + `TMR_W'(1);
			end
		end
	end

	// Dominant timeout on a stuck transmit data pin
	always_comb begin
		next_dom_cnt = '0;
		if (!txd_s && st == M_NORMAL) begin
			next_dom_cnt = (dom_cnt == `TMR_W'(DOM_CYC)) ? dom_cnt : dom_cnt + `TMR_W'(1);
		end
	end

	// Mode select window: sample transmit data after the enable fall
	always_comb begin
		next_win_cnt = win_cnt;
		next_win_txd = win_txd;
		if (en_fall && allow_req) begin
			next_win_cnt = 8'(`SELECT_CYCLES);
			next_win_txd = txd_s;
		end else if (en_s) begin
			next_win_cnt = 8'h00; // Enable back high abandons a pending request
		end else if (win_cnt != 8'h00) begin
			next_win_cnt = win_cnt - 8'h01;
			next_win_txd = txd_s; // last sample in window decides
		end
	end

	// Wake detector: fall, dominant beyond wake time, then rise
	always_comb begin
		next_wk = wk;
		next_wake_cnt = wake_cnt;
		if (!(st == M_SILENT || (st == M_SLEEP && pre_s))) begin
			next_wk = W_IDLE;
			next_wake_cnt = '0;
		end else begin
			unique case (wk)
				W_IDLE: begin
					next_wake_cnt = '0;
					if (dom_s && !dom_d) next_wk = W_LOW; // falling bus edge only
				end
				W_LOW: begin
					if (!dom_s) begin
						next_wk = W_IDLE;
					end else if (wake_cnt == `TMR_W'(WAKE_CYC - 1)) begin
						next_wk = W_HELD;
					end else begin
						next_wake_cnt = wake_cnt + `TMR_W'(1);
					end
				end
				W_HELD: begin
					if (!dom_s) next_wk = W_IDLE;
				end
				default: next_wk = W_IDLE;
			endcase
		end
	end

	// Mode sequencer
	always_comb begin
		next_st = st;
		next_src_wake = src_wake;
		next_src_buv = src_buv;
		next_buv_entry = buv_entry;
		if (rst_low && st != M_SLEEP) begin
			next_st = M_FAILSAFE;
			if (st == M_NORMAL && buv_s) begin
				next_src_buv = 1'b1;
				next_buv_entry = 1'b1;
			end
		end else begin
			unique case (st)
				M_FAILSAFE: begin
					if (win_cnt == 8'h01 && buv_entry) begin
						next_st = win_txd ? M_SILENT : M_SLEEP;
						next_buv_entry = 1'b0;
					end else if (en_s && allow_req && !buv_entry) begin
						next_st = M_NORMAL;
					end
				end
				M_NORMAL: begin
					next_src_wake = 1'b0;
					next_src_buv = 1'b0;
					next_buv_entry = 1'b0;
					if (buv_s) begin
						next_st = M_FAILSAFE;
						next_src_buv = 1'b1;
						next_buv_entry = 1'b1;
					end else if (win_cnt == 8'h01) begin
						if (win_txd) next_st = M_SILENT;
						else next_st = M_SLEEP;
					end else if (en_fall && dom_cnt == `TMR_W'(DOM_CYC)) begin
						next_st = M_SLEEP;
					end
				end
				M_SILENT: begin
					if (buv_s) begin
						next_st = M_FAILSAFE;
						next_src_buv = 1'b1;
					end else if (wake_evt) begin
						next_st = M_FAILSAFE;
						next_src_wake = 1'b1;
					end else if (en_s) begin
						next_st = M_NORMAL;
					end
				end
				M_SLEEP: begin
					if (wake_evt || en_s) begin
						next_st = M_FAILSAFE;
						next_src_wake = wake_evt;
					end
				end
			endcase
		end
	end

	// Pin and analogue controls from the next mode
	always_comb begin
		next_reg_on = (next_st != M_SLEEP);
		next_term = (next_st == M_NORMAL || next_st == M_FAILSAFE);
		next_rcv = (next_st != M_SLEEP) || pre_s;
		next_drive = (next_st == M_NORMAL) && !txd_s;
		next_txd_oe = (next_st == M_FAILSAFE);
		next_txd_out = next_src_buv && !next_src_wake;
		unique case (next_st)
			M_NORMAL: next_rxd = !dom_s;
			M_SILENT: next_rxd = 1'b1;
			M_SLEEP: next_rxd = 1'b0;
			default: next_rxd = !(next_src_wake || next_src_buv);
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= M_FAILSAFE;
			wk <= W_IDLE;
			rst_cnt <= '0;
			rst_low <= 1'b1;
			wake_cnt <= '0;
			dom_cnt <= '0;
			win_cnt <= 8'h00;
			win_txd <= 1'b1;
			en_d <= 1'b0;
			dom_d <= 1'b0;
			src_wake <= 1'b0;
			src_buv <= 1'b0;
			buv_entry <= 1'b0;
			regulator_on <= 1'b1;
			termination_on <= 1'b1;
			bus_receiver_on <= 1'b1;
			bus_drive_dominant <= 1'b0;
			txd_oe <= 1'b1;
			txd_out <= 1'b0;
			rxd <= 1'b1;
			reset_output_low <= 1'b1;
			mode <= M_FAILSAFE;
		end else begin
			st <= next_st;
			wk <= next_wk;
			rst_cnt <= next_rst_cnt;
			rst_low <= next_rst_low;
			wake_cnt <= next_wake_cnt;
			dom_cnt <= next_dom_cnt;
			win_cnt <= next_win_cnt;
			win_txd <= next_win_txd;
			en_d <= en_s;
			dom_d <= dom_s;
			src_wake <= next_src_wake;
			src_buv <= next_src_buv;
			buv_entry <= next_buv_entry;
			regulator_on <= next_reg_on;
			termination_on <= next_term;
			bus_receiver_on <= next_rcv;
			bus_drive_dominant <= next_drive;
			txd_oe <= next_txd_oe;
			txd_out <= next_txd_out;
			rxd <= next_rxd;
			reset_output_low <= next_rst_low;
			mode <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	sleep_outputs_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == M_SLEEP) |-> (!regulator_on && !rxd && reset_output_low))
		else $error("sleep outputs wrong");
	reset_forces_fs_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_low && st == M_NORMAL) |=> (st == M_FAILSAFE))
		else $error("reset did not force fail-safe");
	no_req_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_low && st == M_FAILSAFE) |=> (st != M_NORMAL))
		else $error("mode changed during reset hold");
	silent_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == M_SILENT) |-> (!termination_on && !bus_drive_dominant && rxd))
		else $error("silent outputs wrong");
	uv_normal_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st == M_NORMAL && buv_s && !rst_low) |=> (st == M_FAILSAFE && src_buv))
		else $error("undervoltage did not leave normal");
	wake_src_a: assert property (@(posedge clk) disable iff (!rst_n)
		(txd_oe && src_wake) |-> (!txd_out && !rxd))
		else $error("wake source code wrong");
	wake_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st == M_SILENT && wake_evt && !buv_s && !rst_low) |=> (st == M_FAILSAFE))
		else $error("wake did not enter fail-safe");
	normal_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st == M_NORMAL && !buv_s && !rst_low) |=> (!src_wake))
		else $error("wake source not cleared");
	cv_silent: cover property (@(posedge clk) disable iff (!rst_n) st == M_SILENT);
	cv_sleep: cover property (@(posedge clk) disable iff (!rst_n) st == M_SLEEP);
	cv_wake: cover property (@(posedge clk) disable iff (!rst_n) wake_evt);
	cv_stuck: cover property (@(posedge clk) disable iff (!rst_n)
		st == M_NORMAL && en_fall && dom_cnt == `TMR_W'(DOM_CYC));
	cv_buv_select: cover property (@(posedge clk) disable iff (!rst_n)
		st == M_FAILSAFE && buv_entry && win_cnt == 8'h01);
	// Outputs outside the select paths
	failsafe_out_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == M_FAILSAFE) |-> (txd_oe && regulator_on && !bus_drive_dominant))
		else $error("fail-safe outputs wrong");
	no_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode != M_NORMAL) |-> !bus_drive_dominant)
		else $error("bus driven outside normal");
	buv_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		(txd_oe && src_buv && !src_wake) |-> (txd_out && !rxd))
		else $error("undervoltage source code wrong");
	// Select paths out of normal
	sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st == M_NORMAL && win_cnt == 8'h01 && !win_txd && !buv_s && !rst_low)
		|=> (st == M_SLEEP))
		else $error("sleep request not taken");
	stuck_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st == M_NORMAL && en_fall && dom_cnt == `TMR_W'(DOM_CYC) && !buv_s && !rst_low)
		|=> (st == M_SLEEP))
		else $error("stuck transmit did not allow sleep");
endmodule // lin_sbc_mode_control
`default_nettype wire

// ===== test/lin_host_model.sv
// Purpose: Host pin model facing the LIN mode controller
// Assumes: Bench gives the wanted enable and transmit data levels
// Notes: Transmit data is two-way; the device wins while its enable is high
`timescale 1ns/1ps
`default_nettype none
module lin_host_model (
	// Wanted host levels
	input wire logic host_en,
	input wire logic host_txd,
	// Device side of the two-way pin
	input wire logic txd_out,
	input wire logic txd_oe,
	// Resolved pins
	output logic enable_pin,
	output logic txd_in
);
	// Enable is a plain host output
	assign enable_pin = host_en;
	// Host level held steady by the bench across the select window
	assign txd_in = txd_oe ? txd_out : host_txd;
endmodule // lin_host_model
`default_nettype wire

// ===== test/lin_sbc_mode_control_tb.sv
// Purpose: Self-checking bench of the LIN mode controller
// Assumes: Short timer parameters, inputs change at the falling edge
// Notes: Each scenario except t_normal waits on mode under a bounded count
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: value mismatch", $time); end end
module lin_sbc_mode_control_tb;
	import lin_mode_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_en = 1'b0;
	logic host_txd = 1'b1;
	logic battery_uv = 1'b0;
	logic vcc_uv = 1'b0;
	logic bus_dominant = 1'b0;
	logic bus_prewake = 1'b0;
	wire logic enable_pin, txd_in, txd_out, txd_oe, rxd, reset_output_low;
	wire logic regulator_on, bus_drive_dominant, termination_on, bus_receiver_on;
	wire logic [1:0] mode;
	int error_cnt = 0;
	int n_checks = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #25 clk = ~clk;
	lin_host_model u_host (.host_en(host_en), .host_txd(host_txd), .txd_out(txd_out),
		.txd_oe(txd_oe), .enable_pin(enable_pin), .txd_in(txd_in));
	lin_sbc_mode_control #(.RESET_CYC(20), .WAKE_CYC(8), .DOM_CYC(16)) u_dut (
		.clk(clk), .rst_n(rst_n), .enable_pin(enable_pin), .txd_in(txd_in),
		.txd_out(txd_out), .txd_oe(txd_oe), .rxd(rxd), .reset_output_low(reset_output_low),
		.battery_uv(battery_uv), .vcc_uv(vcc_uv), .bus_dominant(bus_dominant),
		.bus_prewake(bus_prewake), .regulator_on(regulator_on),
		.bus_drive_dominant(bus_drive_dominant), .termination_on(termination_on),
		.bus_receiver_on(bus_receiver_on), .mode(mode));

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic wait_mode(input logic [1:0] m, input int lim);
		int i;
		for (i = 0; i < lim && mode !== m; i++) @(negedge clk);
	endtask
	// Enable falls as transmit data takes the chosen level, then window passes
	task automatic select(input logic t);
		@(negedge clk);
		host_txd = t;
		host_en = 1'b0;
		repeat (80) @(negedge clk);
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_power;
		@(negedge clk);
		host_en = 1'b1;
		repeat (10) @(negedge clk);
		`CHK(mode, M_FAILSAFE)
		`CHK(reset_output_low, 1'b1)
		`CHK(regulator_on, 1'b1)
		`CHK(bus_drive_dominant, 1'b0)
		wait_mode(M_NORMAL, 40);
		`CHK(mode, M_NORMAL)
		`CHK(reset_output_low, 1'b0)
		$display("power-up test done");
	endtask
	task automatic t_normal;
		host_txd = 1'b0;
		bus_dominant = 1'b1;
		repeat (8) @(negedge clk);
		`CHK(bus_drive_dominant, 1'b1)
		`CHK(rxd, 1'b0)
		`CHK(termination_on, 1'b1)
		host_txd = 1'b1;
		bus_dominant = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(bus_drive_dominant, 1'b0)
		`CHK(rxd, 1'b1)
		$display("normal test done");
	endtask
	task automatic t_silent_wake;
		bus_dominant = 1'b1;
		select(1'b1);
		`CHK(mode, M_SILENT)
		`CHK(termination_on, 1'b0)
		`CHK(regulator_on, 1'b1)
		`CHK(bus_drive_dominant, 1'b0)
		`CHK(rxd, 1'b1)
		bus_dominant = 1'b0;
		repeat (12) @(negedge clk);
		`CHK(mode, M_SILENT)
		bus_prewake = 1'b1;
		bus_dominant = 1'b1;
		repeat (3) @(negedge clk);
		bus_dominant = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(mode, M_SILENT)
		bus_dominant = 1'b1;
		repeat (20) @(negedge clk);
		`CHK(mode, M_SILENT)
		bus_dominant = 1'b0;
		bus_prewake = 1'b0;
		wait_mode(M_FAILSAFE, 20);
		`CHK(mode, M_FAILSAFE)
		`CHK(txd_oe, 1'b1)
		`CHK(txd_out, 1'b0)
		`CHK(rxd, 1'b0)
		host_en = 1'b1;
		wait_mode(M_NORMAL, 40);
		`CHK(mode, M_NORMAL)
		`CHK(txd_oe, 1'b0)
		`CHK(rxd, 1'b1)
		$display("silent and wake test done");
	endtask
	task automatic t_sleep;
		select(1'b0);
		`CHK(mode, M_SLEEP)
		`CHK(regulator_on, 1'b0)
		`CHK(reset_output_low, 1'b1)
		`CHK(rxd, 1'b0)
		`CHK(termination_on, 1'b0)
		`CHK(bus_receiver_on, 1'b0)
		bus_prewake = 1'b1;
		repeat (8) @(negedge clk);
		`CHK(bus_receiver_on, 1'b1)
		bus_prewake = 1'b0;
		host_txd = 1'b1;
		host_en = 1'b1;
		wait_mode(M_FAILSAFE, 20);
		`CHK(mode, M_FAILSAFE)
		wait_mode(M_NORMAL, 60);
		`CHK(mode, M_NORMAL)
		$display("sleep test done");
	endtask
	task automatic t_undervolt;
		battery_uv = 1'b1;
		wait_mode(M_FAILSAFE, 20);
		`CHK(mode, M_FAILSAFE)
		`CHK(txd_out, 1'b1)
		`CHK(rxd, 1'b0)
		battery_uv = 1'b0;
		repeat (30) @(negedge clk);
		`CHK(reset_output_low, 1'b0)
		`CHK(mode, M_FAILSAFE)
		select(1'b1);
		`CHK(mode, M_SILENT)
		host_en = 1'b1;
		wait_mode(M_NORMAL, 40);
		vcc_uv = 1'b1;
		repeat (8) @(negedge clk);
		`CHK(reset_output_low, 1'b1)
		`CHK(mode, M_FAILSAFE)
		vcc_uv = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(mode, M_FAILSAFE)
		wait_mode(M_NORMAL, 60);
		`CHK(mode, M_NORMAL)
		$display("undervoltage test done");
	endtask
	// Transmit data held low past the dominant timeout, then enable falls
	task automatic t_stuck;
		host_txd = 1'b0;
		repeat (30) @(negedge clk);
		host_en = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(mode, M_SLEEP)
		host_txd = 1'b1;
		host_en = 1'b1;
		wait_mode(M_NORMAL, 60);
		`CHK(mode, M_NORMAL)
		repeat (40) @(negedge clk);
		`CHK(mode, M_NORMAL)
		$display("stuck transmit test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_power();
		t_normal();
		t_silent_wake();
		t_sleep();
		t_undervolt();
		t_stuck();
		wrap_up();
	end
	initial begin
		#(20000 * 50);
		error_cnt++;
		wrap_up();
	end
endmodule // lin_sbc_mode_control_tb
`default_nettype wire
